// file: src/csq_pkg.sv
// csq_pkg: constants, encodings and option layout of the start-up sequencer.
// assumes a single 100 MHz system clock and a 32-bit plain register port.
package csq_pkg;

   localparam int CLK_PERIOD_NS = 10;

   // register byte offsets
   localparam logic [3:0] OFS_OPTIONS = 4'h0;
   localparam logic [3:0] OFS_CONTROL = 4'h4;
   localparam logic [3:0] OFS_STATUS  = 4'h8;

   // control register bit positions
   localparam int CTL_START_BIT = 0;
   localparam int CTL_RESTART_BIT = 1;

   // phase selector codes for write enable / three-state and lock wait
   localparam logic [2:0] SEL_KEEP = 3'h0;
   localparam logic [2:0] SEL_DONE = 3'h7;
   localparam logic [3:0] LOCK_SKIP_LOCK_WAIT = 4'hF;

   // oscillator rates, index 0 is the slowest
   localparam logic [2:0] RATE_1MHZ = 3'h0;
   localparam logic [2:0] RATE_MAX  = 3'h5;
   localparam int OSC_PERIOD_NS [6] = '{1000, 333, 166, 80, 40, 20};

   // sequence clock sources
   localparam logic [1:0] SRC_CCLK = 2'h0;
   localparam logic [1:0] SRC_USER = 2'h1;
   localparam logic [1:0] SRC_TEST = 2'h2;

   localparam int NUM_CLKMGR = 4;

   typedef struct packed {
      logic [5:0] reserved;
      logic       ext_cclk;
      logic [3:0] lock_wait_mask;
      logic       done_input_pipeline;
      logic       active_done_drive;
      logic [3:0] lock_wait_phase_select;
      logic [2:0] three_state_phase_select;
      logic [2:0] write_enable_phase_select;
      logic [2:0] done_phase_select;
      logic [1:0] sequence_clock_select;
      logic [2:0] oscillator_rate_select;
   } csq_options_t;

   localparam csq_options_t OPTIONS_RESET = '{
      reserved: 6'h00, ext_cclk: 1'b0, lock_wait_mask: 4'h0,
      done_input_pipeline: 1'b0, active_done_drive: 1'b0,
      lock_wait_phase_select: LOCK_SKIP_LOCK_WAIT, three_state_phase_select: 3'h5,
      write_enable_phase_select: 3'h6, done_phase_select: 3'h4,
      sequence_clock_select: SRC_CCLK, oscillator_rate_select: RATE_1MHZ};

   typedef enum logic [2:0] {
      ST_CONFIG   = 3'b001,
      ST_RUN      = 3'b010,
      ST_COMPLETE = 3'b100
   } csq_state_t;

endpackage : csq_pkg

// file: src/csq_sequencer.sv
// csq_sequencer: start-up sequencer moving the device from configuration to user mode.
// assumes option loads arrive over the plain register port on CLOCK_IN; DONE, the lock
// inputs and foreign clocks are sampled through two flip-flops, the user set/reset and three-state pins are not.
//
// Local design decisions: the placing of the registers and the strobed register port.

module csq_sequencer
   import csq_pkg::*;
(
   input  wire logic                  CLOCK_IN,
   input  wire logic                  RST_IN,
   input  wire logic [3:0]            ADDR_IN,
   input  wire logic [31:0]           WR_DATA_IN,
   input  wire logic                  WR_STB_IN,
   input  wire logic                  RD_STB_IN,
   output logic      [31:0]           RD_DATA_OUT,
   input  wire logic                  EXT_CCLK_IN,
   input  wire logic                  USER_CLK_IN,
   input  wire logic                  TEST_CLK_IN,
   input  wire logic [NUM_CLKMGR-1:0] CLKMGR_LOCKED_IN,
   input  wire logic                  USER_SET_RESET_IN,
   input  wire logic                  USER_THREE_STATE_IN,
   input  wire logic                  DONE_IN,
   output logic                       DONE_OUT,
   output logic                       DONE_OE_N_OUT,
   output logic                       CCLK_OUT,
   output logic                       GLOBAL_WRITE_ENABLE_OUT,
   output logic                       GLOBAL_THREE_STATE_OUT,
   output logic                       GLOBAL_SET_RESET_OUT
);

   csq_options_t          opt_ff;
   csq_options_t          wr_opt;
   csq_state_t            state_ff;
   logic [2:0]            phase_ff;
   logic [2:0]            gwe_phase_ff;
   logic [2:0]            gts_phase_ff;
   logic                  rate_loaded_ff;
   logic [6:0]            osc_cnt_ff;
   logic                  cclk_ff;
   logic                  cclk_tick_ff;
   logic [2:0]            ext_sync_ff;
   logic [2:0]            user_sync_ff;
   logic [2:0]            test_sync_ff;
   logic [1:0]            done_sync_ff;
   logic                  done_pipe_ff;
   logic [NUM_CLKMGR-1:0] lock_s1_ff;
   logic [NUM_CLKMGR-1:0] lock_s2_ff;
   logic                  done_act_ff;
   logic                  gwe_ff;
   logic                  gts_ff;
   logic                  gsr_ff;
   logic [31:0]           rd_data_ff;

   logic                  wr_options;
   logic                  start_cmd;
   logic                  restart_cmd;
   logic                  step;
   logic                  done_seen;
   logic                  lock_ok;
   logic                  stalled;
   logic [2:0]            nxt_phase;
   logic                  gwe_cond;
   logic                  gts_cond;
   logic [2:0]            rate_idx;
   logic [6:0]            osc_div;

   assign wr_options  = WR_STB_IN && ADDR_IN == OFS_OPTIONS && state_ff == ST_CONFIG;
   assign wr_opt      = csq_options_t'(WR_DATA_IN[$bits(csq_options_t)-1:0]);
   assign start_cmd   = WR_STB_IN && ADDR_IN == OFS_CONTROL && WR_DATA_IN[CTL_START_BIT];
   assign restart_cmd = WR_STB_IN && ADDR_IN == OFS_CONTROL && WR_DATA_IN[CTL_RESTART_BIT];

   // options load; a keep code leaves the phase in force untouched
   always_ff @(posedge CLOCK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         opt_ff         <= OPTIONS_RESET;
         gwe_phase_ff   <= OPTIONS_RESET.write_enable_phase_select;
         gts_phase_ff   <= OPTIONS_RESET.three_state_phase_select;
         rate_loaded_ff <= 1'b0;
      end
      else if (wr_options)
      begin
         opt_ff         <= wr_opt;
         rate_loaded_ff <= 1'b1;
         if (wr_opt.write_enable_phase_select != SEL_KEEP)
         begin
            gwe_phase_ff <= wr_opt.write_enable_phase_select;
         end
         if (wr_opt.three_state_phase_select != SEL_KEEP)
         begin
            gts_phase_ff <= wr_opt.three_state_phase_select;
         end
      end
   end

   // internal configuration oscillator as an enable divider
   assign rate_idx = (rate_loaded_ff && opt_ff.oscillator_rate_select <= RATE_MAX)
                     ? opt_ff.oscillator_rate_select : RATE_1MHZ;
   always_comb
   begin
      osc_div = 7'(OSC_PERIOD_NS[0] / CLK_PERIOD_NS);
      case (rate_idx)
         3'h1:    osc_div = 7'(OSC_PERIOD_NS[1] / CLK_PERIOD_NS);
         3'h2:    osc_div = 7'(OSC_PERIOD_NS[2] / CLK_PERIOD_NS);
         3'h3:    osc_div = 7'(OSC_PERIOD_NS[3] / CLK_PERIOD_NS);
         3'h4:    osc_div = 7'(OSC_PERIOD_NS[4] / CLK_PERIOD_NS);
         3'h5:    osc_div = 7'(OSC_PERIOD_NS[5] / CLK_PERIOD_NS);
         default: osc_div = 7'(OSC_PERIOD_NS[0] / CLK_PERIOD_NS);
      endcase
   end

   always_ff @(posedge CLOCK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         osc_cnt_ff   <= 7'h00;
         cclk_ff      <= 1'b0;
         cclk_tick_ff <= 1'b0;
      end
      else
      begin
         cclk_tick_ff <= 1'b0;
         // rate change takes hold at once; a count already past the new end wraps on the next cycle
         if (osc_cnt_ff >= osc_div - 7'h01)
         begin
            osc_cnt_ff   <= 7'h00;
            cclk_ff      <= 1'b1;
            cclk_tick_ff <= 1'b1;
         end
         else
         begin
            osc_cnt_ff <= osc_cnt_ff + 7'h01;
            if (osc_cnt_ff == (osc_div >> 1) - 7'h01)
            begin
               cclk_ff <= 1'b0;
            end
         end
      end
   end
   assign CCLK_OUT = cclk_ff;

   // pin and foreign clock sampling; stage 0 is read only by stage 1
   always_ff @(posedge CLOCK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         ext_sync_ff  <= 3'h0;
         user_sync_ff <= 3'h0;
         test_sync_ff <= 3'h0;
         done_sync_ff <= 2'h0;
         lock_s1_ff   <= '0;
         lock_s2_ff   <= '0;
      end
      else
      begin
         ext_sync_ff  <= {ext_sync_ff[1:0], EXT_CCLK_IN};
         user_sync_ff <= {user_sync_ff[1:0], USER_CLK_IN};
         test_sync_ff <= {test_sync_ff[1:0], TEST_CLK_IN};
         done_sync_ff <= {done_sync_ff[0], DONE_IN};
         lock_s1_ff   <= CLKMGR_LOCKED_IN;
         lock_s2_ff   <= lock_s1_ff;
      end
   end

   // one-cycle enable per rising edge of the chosen sequence clock
   always_comb
   begin
      case (opt_ff.sequence_clock_select)
         SRC_USER: step = user_sync_ff[1] && !user_sync_ff[2];
         SRC_TEST: step = test_sync_ff[1] && !test_sync_ff[2];
         default:  step = opt_ff.ext_cclk ? (ext_sync_ff[1] && !ext_sync_ff[2])
                                          : cclk_tick_ff;
      endcase
   end

   // extra DONE stage clocked by the sequence step
   always_ff @(posedge CLOCK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         done_pipe_ff <= 1'b0;
      end
      else if (state_ff == ST_CONFIG)
      begin
         // a stale high from the last run must not release the next one
         done_pipe_ff <= 1'b0;
      end
      else if (step)
      begin
         done_pipe_ff <= done_sync_ff[1];
      end
   end
   assign done_seen = opt_ff.done_input_pipeline ? done_pipe_ff
                                                 : done_sync_ff[1];

   assign lock_ok = &(lock_s2_ff | ~opt_ff.lock_wait_mask);
   assign stalled = opt_ff.lock_wait_phase_select != LOCK_SKIP_LOCK_WAIT &&
                    {1'b0, phase_ff} == opt_ff.lock_wait_phase_select &&
                    !lock_ok;
   assign nxt_phase = (phase_ff == 3'h6) ? phase_ff : phase_ff + 3'h1;

   assign gwe_cond = (gwe_phase_ff == SEL_DONE) ? done_seen
                                                : nxt_phase >= gwe_phase_ff;
   assign gts_cond = (gts_phase_ff == SEL_DONE) ? done_seen
                                                : nxt_phase >= gts_phase_ff;

   // phase walk and completion
   always_ff @(posedge CLOCK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         state_ff <= ST_CONFIG;
         phase_ff <= 3'h0;
      end
      else
      begin
         case (state_ff)
            ST_CONFIG:
            begin
               if (start_cmd)
               begin
                  state_ff <= ST_RUN;
                  phase_ff <= 3'h0;
               end
            end
            ST_RUN:
            begin
               if (step && !stalled)
               begin
                  phase_ff <= nxt_phase;
                  if (phase_ff == 3'h6 && gwe_ff && !gts_ff && done_act_ff)
                  begin
                     state_ff <= ST_COMPLETE;
                  end
               end
            end
            ST_COMPLETE:
            begin
               if (restart_cmd)
               begin
                  state_ff <= ST_CONFIG;
                  phase_ff <= 3'h0;
               end
            end
            default:
            begin
               state_ff <= ST_CONFIG;
            end
         endcase
      end
   end

   // global event flags, sticky once fired until a restart
   always_ff @(posedge CLOCK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         done_act_ff <= 1'b0;
         gwe_ff      <= 1'b0;
         gts_ff      <= 1'b1;
         gsr_ff      <= 1'b1;
      end
      else if (state_ff == ST_CONFIG)
      begin
         done_act_ff <= 1'b0;
         gwe_ff      <= 1'b0;
         gts_ff      <= 1'b1;
         gsr_ff      <= 1'b1;
      end
      else if (state_ff == ST_RUN && step && !stalled)
      begin
         gsr_ff <= 1'b0;
         if (nxt_phase >= opt_ff.done_phase_select)
         begin
            done_act_ff <= 1'b1;
         end
         if (gwe_cond)
         begin
            gwe_ff <= 1'b1;
         end
         if (gts_cond)
         begin
            gts_ff <= 1'b0;
         end
      end
   end

   // application controls only count once configuration is over
   assign GLOBAL_SET_RESET_OUT    = gsr_ff || (state_ff == ST_COMPLETE && USER_SET_RESET_IN);
   assign GLOBAL_THREE_STATE_OUT  = gts_ff || (state_ff == ST_COMPLETE && USER_THREE_STATE_IN);
   assign GLOBAL_WRITE_ENABLE_OUT = gwe_ff;

   // open-drain DONE: low until activated, then released or driven high
   assign DONE_OUT      = done_act_ff;
   assign DONE_OE_N_OUT = done_act_ff && !opt_ff.active_done_drive;

   // register read port, data one cycle after the strobe
   always_ff @(posedge CLOCK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         rd_data_ff <= 32'h0000_0000;
      end
      else if (RD_STB_IN)
      begin
         case (ADDR_IN)
            OFS_OPTIONS: rd_data_ff <= 32'(opt_ff);
            OFS_STATUS:  rd_data_ff <= {10'h000, done_sync_ff[1], rate_loaded_ff,
                                        gwe_phase_ff, gts_phase_ff, lock_s2_ff,
                                        gsr_ff, gts_ff, gwe_ff, done_act_ff,
                                        state_ff, phase_ff};
            default:     rd_data_ff <= 32'h0000_0000;
         endcase
      end
      else
      begin
         rd_data_ff <= 32'h0000_0000;
      end
   end
   assign RD_DATA_OUT = rd_data_ff;

   a_phase_one_step: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      state_ff == ST_RUN && step && !stalled && phase_ff < 3'h6
      |=> phase_ff == $past(phase_ff) + 3'h1)
      else $error("phase did not advance by one");
   a_phase_hold_idle: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      state_ff == ST_RUN && !step |=> $stable(phase_ff))
      else $error("phase moved without a sequence edge");
   a_lock_stall: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      state_ff == ST_RUN && stalled |=> $stable(phase_ff))
      else $error("phase moved while waiting for lock");
   a_done_phase: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      state_ff == ST_RUN && done_act_ff && !$past(done_act_ff)
      |-> phase_ff >= opt_ff.done_phase_select)
      else $error("DONE activated before its phase");
   a_gwe_wait_done: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      $rose(gwe_ff) && gwe_phase_ff == SEL_DONE |-> $past(done_seen))
      else $error("write enable before DONE seen");
   a_gts_wait_done: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      $fell(gts_ff) && gts_phase_ff == SEL_DONE |-> $past(done_seen))
      else $error("three-state released before DONE seen");
   a_gsr_config: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      state_ff == ST_CONFIG |=> GLOBAL_SET_RESET_OUT)
      else $error("set/reset not held in configuration");
   a_done_release: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      !done_act_ff |-> !DONE_OE_N_OUT && !DONE_OUT)
      else $error("DONE not driven low before activation");
   a_options_stable: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      state_ff == ST_RUN ##1 state_ff == ST_RUN |-> $stable(opt_ff))
      else $error("options changed during sequence");
   a_osc_slow_first: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
      !rate_loaded_ff |-> osc_div == 7'(OSC_PERIOD_NS[0] / CLK_PERIOD_NS))
      else $error("oscillator fast before rate load");

endmodule : csq_sequencer

// file: test/csq_done_partner.sv
// csq_done_partner: another device on the wired DONE line, holding it low until done.
// assumes an external pull-up; the bench forms the wire level from all drivers.
module csq_done_partner (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       release_in,
   input  wire logic [4:0] delay_in,
   output logic            low_out
);
   logic [4:0] wait_ff;

   // open-drain only, never drives high: one active driver per chain at most
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in || !release_in)
      begin
         wait_ff <= 5'h00;
         low_out <= 1'b1;
      end
      else if (wait_ff >= delay_in)
         low_out <= 1'b0;
      else
         wait_ff <= wait_ff + 5'h01;
   end
endmodule : csq_done_partner

// file: test/csq_sequencer_bench.sv
// csq_sequencer_bench: corner and random start-up runs checked against a step model.
// assumes the option layout of csq_pkg and one other device sharing DONE.
module csq_sequencer_bench
   import csq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  clk, rst, wr_stb, rd_stb, ext_clk, user_clk, test_clk;
   logic                  user_sr, user_ts, done_wire, done_out, done_oe_n;
   logic                  cclk, global_write_enable, global_three_state, global_set_reset, p_rel, p_low;
   logic [3:0]            addr;
   logic [31:0]           wdata, rdata, s;
   logic [NUM_CLKMGR-1:0] locks;
   logic [4:0]            p_dly;
   int                    error_cnt, checks, cyc, ph, lk;
   logic                  dact, gts_rel, gwe_on, pipe_ff, cmpl;
   logic [2:0]            gts_force, gwe_force;
   csq_options_t          opt, o;

   // pull-up wins only when nobody pulls low
   assign done_wire = !((done_oe_n === 1'b0 && done_out === 1'b0) || p_low);

   csq_sequencer i_csq_sequencer (
      .CLOCK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WR_DATA_IN(wdata),
      .WR_STB_IN(wr_stb), .RD_STB_IN(rd_stb), .RD_DATA_OUT(rdata),
      .EXT_CCLK_IN(ext_clk), .USER_CLK_IN(user_clk), .TEST_CLK_IN(test_clk),
      .CLKMGR_LOCKED_IN(locks), .USER_SET_RESET_IN(user_sr),
      .USER_THREE_STATE_IN(user_ts), .DONE_IN(done_wire), .DONE_OUT(done_out),
      .DONE_OE_N_OUT(done_oe_n), .CCLK_OUT(cclk), .GLOBAL_WRITE_ENABLE_OUT(global_write_enable),
      .GLOBAL_THREE_STATE_OUT(global_three_state), .GLOBAL_SET_RESET_OUT(global_set_reset));

   csq_done_partner i_csq_done_partner (
      .clk_in(clk), .rst_in(rst), .release_in(p_rel), .delay_in(p_dly), .low_out(p_low));

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         $display("BAD %0t run did not finish", $time);
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_stb <= 1'b1;
      addr   <= a;
      wdata  <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_stb <= 1'b1;
      addr   <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd

   task automatic reset_dut();
      @(posedge clk);
      rst   <= 1'b1;
      p_rel <= 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      gts_force = OPTIONS_RESET.three_state_phase_select;
      gwe_force = OPTIONS_RESET.write_enable_phase_select;
   endtask : reset_dut

   task automatic measure(input int r);
      longint t0;
      int     d;
      repeat (2) @(posedge cclk);
      t0 = $time;
      @(posedge cclk);
      d = int'(($time - t0) / CLK_PERIOD_NS) - OSC_PERIOD_NS[r] / CLK_PERIOD_NS;
      chk_bit(d >= -1 && d <= 1, 1'b1, "oscillator period");
   endtask : measure

   task automatic pulse(input logic [1:0] k, output logic dw);
      @(posedge clk);
      ext_clk  <= (k == SRC_CCLK);
      user_clk <= (k == SRC_USER);
      test_clk <= (k == SRC_TEST);
      // DONE level that the first synchroniser stage takes at the next edge
      @(negedge clk);
      dw = done_wire;
      repeat (3) @(posedge clk);
      {ext_clk, user_clk, test_clk} <= 3'h0;
      repeat (3) @(posedge clk);
   endtask : pulse

   function automatic logic reached(input logic [2:0] sel, input logic dn, input logic old);
      if (sel == SEL_DONE)
         return old | dn;
      return old | (ph >= int'(sel));
   endfunction : reached

   // one step of the selected clock; the other two sources pulse first and must not count
   task automatic step(input logic all_lock);
      logic seen, dn, stall;
      @(posedge clk);
      locks   <= all_lock ? '1 : NUM_CLKMGR'($urandom);
      user_sr <= 1'($urandom);
      user_ts <= 1'($urandom);
      repeat (4) @(posedge clk);
      for (int k = 0; k < 3; k++)
         if (2'(k) != opt.sequence_clock_select)
            pulse(2'(k), seen);
      pulse(opt.sequence_clock_select, seen);
      stall = opt.lock_wait_phase_select <= 4'h6 && ph == int'(opt.lock_wait_phase_select)
              && (locks & opt.lock_wait_mask) != opt.lock_wait_mask;
      // the pipeline stage moves on every sequence edge, stalled or not
      dn      = opt.done_input_pipeline ? pipe_ff : seen;
      pipe_ff = seen;
      if (!cmpl && !stall)
      begin
         if (ph == 6 && dact && gts_rel && gwe_on)
            cmpl = 1'b1;
         else
         begin
            if (ph < 6)
               ph++;
            dact    = dact | (ph >= int'(opt.done_phase_select));
            gts_rel = reached(gts_force, dn, gts_rel);
            gwe_on  = reached(gwe_force, dn, gwe_on);
         end
      end
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, s);
      chk_word(32'(s[5:3]), 32'(cmpl ? ST_COMPLETE : ST_RUN), "state");
      if (!cmpl)
         chk_word(32'(s[2:0]), 32'(ph), "phase");
      chk_bit(global_write_enable, gwe_on, "write enable");
      chk_bit(global_three_state, cmpl ? user_ts : !gts_rel, "three-state");
      chk_bit(done_oe_n, dact & !opt.active_done_drive, "done enable");
      chk_bit(done_out, dact, "done value");
      if (ph > 0)
         chk_bit(global_set_reset, cmpl & user_sr, "set/reset");
   endtask : step

   task automatic run_case(input int rel, input int id);
      opt = o;
      if (o.three_state_phase_select != SEL_KEEP)
         gts_force = o.three_state_phase_select;
      if (o.write_enable_phase_select != SEL_KEEP)
         gwe_force = o.write_enable_phase_select;
      ph = 0;
      {dact, gts_rel, gwe_on, pipe_ff, cmpl} = 5'h00;
      p_dly <= 5'($urandom_range(0, 12));
      wr(OFS_OPTIONS, 32'(o));
      wr(OFS_CONTROL, 32'h0000_0001);
      for (int i = 0; i < 10; i++)
      begin
         if (i == rel)
            p_rel <= 1'b1;
         if (i == 2)
            wr(OFS_OPTIONS, $urandom);
         step(1'b0);
      end
      p_rel <= 1'b1;
      for (int i = 0; i < 12 && !cmpl; i++)
         step(1'b1);
      chk_word(32'(s[5:3]), 32'(ST_COMPLETE), "completion");
      $display("test %0d done", id);
   endtask : run_case

   initial
   begin
      {clk, rst, wr_stb, rd_stb, ext_clk, user_clk, test_clk} = 7'h20;
      {user_sr, user_ts, p_rel, addr, wdata, locks, p_dly} = '0;
      void'($urandom(32'h9B98B616));
      reset_dut();
      chk_bit(global_write_enable, 1'b0, "write enable");
      chk_bit(global_three_state, 1'b1, "three-state");
      chk_bit(global_set_reset, 1'b1, "set/reset");
      chk_bit(done_oe_n, 1'b0, "done enable");
      rd(OFS_STATUS, s);
      chk_word(32'(s[5:3]), 32'(ST_CONFIG), "state");
      chk_bit(s[20], 1'b0, "rate loaded");
      rd(4'hC, s);
      chk_word(s, 32'h0000_0000, "unmapped read");
      rd(OFS_CONTROL, s);
      chk_word(s, 32'h0000_0000, "control read");
      measure(0);
      o = OPTIONS_RESET;
      for (int r = 1; r < 6; r++)
      begin
         o.oscillator_rate_select = 3'(r);
         wr(OFS_OPTIONS, 32'(o));
         measure(r);
      end
      rd(OFS_STATUS, s);
      chk_bit(s[20], 1'b1, "rate loaded");
      $display("test 0 done");
      p_rel <= 1'b1;
      wr(OFS_CONTROL, 32'h0000_0001);
      for (int i = 0; i < 100 && s[5:3] !== ST_COMPLETE; i++)
         rd(OFS_STATUS, s);
      chk_word(32'(s[5:3]), 32'(ST_COMPLETE), "internal run");
      chk_bit(global_write_enable, 1'b1, "write enable");
      reset_dut();
      o = OPTIONS_RESET;
      o.ext_cclk = 1'b1;
      run_case(0, 1);
      reset_dut();
      {o.write_enable_phase_select, o.three_state_phase_select} = {SEL_DONE, SEL_DONE};
      {o.done_input_pipeline, o.active_done_drive} = 2'h3;
      o.sequence_clock_select = SRC_USER;
      run_case(6, 2);
      reset_dut();
      o = OPTIONS_RESET;
      {o.ext_cclk, o.lock_wait_phase_select, o.lock_wait_mask} = 9'h10F;
      {o.done_phase_select, o.three_state_phase_select, o.write_enable_phase_select} = 9'h069;
      o.sequence_clock_select = SRC_TEST;
      run_case(0, 3);
      for (int i = 4; i < 10; i++)
      begin
         reset_dut();
         o = OPTIONS_RESET;
         o.ext_cclk = 1'b1;
         o.done_phase_select = 3'($urandom_range(1, 6));
         o.write_enable_phase_select = 3'($urandom_range(1, 7));
         o.three_state_phase_select = 3'($urandom_range(1, 7));
         lk = $urandom_range(0, 7);
         o.lock_wait_phase_select = (lk == 7) ? LOCK_SKIP_LOCK_WAIT : 4'(lk);
         o.lock_wait_mask = 4'($urandom);
         {o.active_done_drive, o.done_input_pipeline} = 2'($urandom);
         o.sequence_clock_select = 2'($urandom_range(0, 2));
         run_case($urandom_range(0, 9), i);
      end
      // restart without reset so the phases in force survive into the next load
      wr(OFS_CONTROL, 32'h0000_0002);
      p_rel <= 1'b0;
      {o.three_state_phase_select, o.write_enable_phase_select} = {SEL_KEEP, SEL_KEEP};
      wr(OFS_OPTIONS, 32'(o));
      rd(OFS_STATUS, s);
      chk_word(32'(s[5:3]), 32'(ST_CONFIG), "restart state");
      chk_word(32'(s[19:14]), 32'({gwe_force, gts_force}), "kept phases");
      run_case(3, 10);
      end_sim();
   end
endmodule : csq_sequencer_bench
